/* File: design/hws_sequencer.sv */
// Waveform slot sequencer with APB register access
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Delay bit set: slot idles, no drive
// - Delay lasts field value times 10 ms
// - Delay bit clear: field is effect id
// - Effect id indexes the built-in library
// - Trigger bit starts playback at first slot
// - After effect ends, fetch following slot
// - Sequence ends after eighth slot
// - Zero identifier stops sequence, plays nothing
module hws_sequencer
	import hws_pkg::*;
#(
	parameter int TICK_CYCLES = HWS_TICK_CYCLES
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Effect library playback port
	output logic EFFECT_START,
	output logic [6:0] EFFECT_INDEX,
	input wire logic EFFECT_DONE,
	// Sequencer state
	output logic BUSY,
	output logic IDLING
);

	// Slot storage, one byte per slot
	logic [7:0] slot [HWS_SLOTS]; // Eight sequence slots
	logic [7:0] next_slot [HWS_SLOTS]; // Slot values after bus writes
	// Walk position and delay countdown
	logic [2:0] pos; // Current slot position
	logic [2:0] next_pos; // Position after this cycle
	logic [6:0] wait_left; // Remaining delay units
	logic [6:0] next_wait_left; // Delay units after this cycle
	// Run flag seen by software as the trigger bit
	logic trigger; // Trigger bit, cleared by hardware at end
	logic next_trigger; // Trigger after set and clear
	// Sequencer state
	hws_state_e state; // Current walk state
	hws_state_e next_state; // Walk state after this cycle
	// Playback port and read data next values
	logic next_start; // Start pulse for the next cycle
	logic [6:0] next_index; // Effect index for the next cycle
	logic [31:0] next_prdata; // Read data for the next cycle
	// Bus decode helpers
	logic [7:0] idx; // Register index from byte address
	logic wr_en; // Write takes effect this edge
	logic rd_en; // Read data captured this edge
	logic [7:0] cur; // Slot under the sequencer
	logic go_set; // Software sets trigger
	// Carrier to the tick divider
	hws_tick_if tk ();

	// Timebase divider
	hws_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.CLK(CLK),
		.RESETN(RESETN),
		.tk(tk)
	);

	// Every transfer completes in its first access cycle
	assign PREADY = 1'b1; // Zero wait states
	// Word-aligned addressing drops the two low bits
	assign idx = PADDR[9:2];
	// Writes land at the end of the access phase
	assign wr_en = PSEL && PENABLE && PWRITE;
	// Reads are looked up in setup so data stands in access
	assign rd_en = PSEL && !PENABLE && !PWRITE;
	// Slot the walk is looking at
	assign cur = slot[pos];
	// Writing zero to the trigger bit has no effect
	assign go_set = wr_en && idx == HWS_IDX_TRIGGER && PWDATA[HWS_TRIGGER_BIT];
	// Sequence in progress while the trigger bit stands
	assign BUSY = trigger;
	// No effect is driven while a delay slot runs
	assign IDLING = state == HWS_WAIT;
	// Divider only counts during a delay, so each delay starts aligned
	assign tk.run = state == HWS_WAIT;

	// Unmapped index answers with an error
	always_comb begin
		PSLVERR = 1'b0;
		if (PSEL && PENABLE) begin
			PSLVERR = !(idx == HWS_IDX_TRIGGER || idx == HWS_IDX_STATUS
				|| (idx >= HWS_IDX_SLOT_FIRST && idx <= HWS_IDX_SLOT_LAST));
		end
	end

	// Read data mux, captured in setup cycle
	always_comb begin
		next_prdata = PRDATA;
		if (rd_en) begin
			// Unused bits and unmapped indices read as zero
			next_prdata = 32'h0000_0000;
			if (idx >= HWS_IDX_SLOT_FIRST && idx <= HWS_IDX_SLOT_LAST) begin
				next_prdata[7:0] = slot[3'(idx - HWS_IDX_SLOT_FIRST)];
			end else if (idx == HWS_IDX_TRIGGER) begin
				next_prdata[HWS_TRIGGER_BIT] = trigger;
			end else if (idx == HWS_IDX_STATUS) begin
				next_prdata[2:0] = pos;
				next_prdata[6:4] = 3'(state);
			end
		end
	end

	// Slot register writes
	always_comb begin
		for (int i = 0; i < HWS_SLOTS; i++) begin
			next_slot[i] = slot[i];
			// Only the low byte of the bus word is stored
			if (wr_en && idx == HWS_IDX_SLOT_FIRST + 8'(i)) begin
				next_slot[i] = PWDATA[7:0];
			end
		end
	end

	// Sequencer walk over the slots
	always_comb begin
		next_state = state;
		next_pos = pos;
		next_wait_left = wait_left;
		next_trigger = trigger;
		next_start = 1'b0;
		next_index = EFFECT_INDEX;
		if (go_set) begin
			next_trigger = 1'b1;
		end
		unique case (state)
			// Wait for software to set the trigger
			HWS_IDLE: begin
				if (trigger) begin
					next_pos = 3'h0;
					next_state = HWS_FETCH;
				end
			end
			// Decode the slot: stop, delay or effect
			HWS_FETCH: begin
				if (cur[HWS_FIELD_W-1:0] == HWS_FIELD_ZERO) begin
					next_state = HWS_IDLE;
					next_trigger = go_set;
				end else if (cur[HWS_DELAY_BIT]) begin
					next_wait_left = cur[HWS_FIELD_W-1:0];
					next_state = HWS_WAIT;
				end else begin
					next_index = cur[HWS_FIELD_W-1:0];
					next_start = 1'b1;
					next_state = HWS_PLAY;
				end
			end
			// Effect runs until the library reports it done
			HWS_PLAY: begin
				if (EFFECT_DONE) begin
					next_state = HWS_NEXT;
				end
			end
			// Count delay units on the divided tick
			HWS_WAIT: begin
				if (tk.tick) begin
					next_wait_left = wait_left - 7'h01;
					if (wait_left == 7'h01) begin
						next_state = HWS_NEXT;
					end
				end
			end
			// Advance, or finish after the last slot
			HWS_NEXT: begin
				if (pos == 3'(HWS_SLOTS - 1)) begin
					next_state = HWS_IDLE;
					next_trigger = go_set;
				end else begin
					next_pos = pos + 3'h1;
					next_state = HWS_FETCH;
				end
			end
			// Unused state codes fall back to idle
			default: begin
				next_state = HWS_IDLE;
			end
		endcase
	end

	// Register all state
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			// All slots empty, walk stopped, outputs quiet
			for (int i = 0; i < HWS_SLOTS; i++) begin
				slot[i] <= HWS_SLOT_RESET;
			end
			state <= HWS_IDLE;
			pos <= 3'h0;
			wait_left <= 7'h00;
			trigger <= 1'b0;
			EFFECT_START <= 1'b0;
			EFFECT_INDEX <= 7'h00;
			PRDATA <= 32'h0000_0000;
		end else begin
			// Take every next value computed above
			slot <= next_slot;
			state <= next_state;
			pos <= next_pos;
			wait_left <= next_wait_left;
			trigger <= next_trigger;
			EFFECT_START <= next_start;
			EFFECT_INDEX <= next_index;
			PRDATA <= next_prdata;
		end
	end

endmodule : hws_sequencer
`default_nettype wire

/* File: design/hws_pkg.sv */
// Package of register map, field layout and timing constants for the sequencer
package hws_pkg;

	// Register indices; the byte address on the bus is four times the index
	localparam logic [7:0] HWS_IDX_TRIGGER = 8'h0C;
	localparam logic [7:0] HWS_IDX_SLOT_FIRST = 8'h0F;
	localparam logic [7:0] HWS_IDX_SLOT_SECOND = 8'h10;
	localparam logic [7:0] HWS_IDX_SLOT_FOUR = 8'h12;
	localparam logic [7:0] HWS_IDX_SLOT_FIVE = 8'h13;
	localparam logic [7:0] HWS_IDX_SLOT_LAST = 8'h16;
	localparam logic [7:0] HWS_IDX_STATUS = 8'h20;
	localparam logic [7:0] HWS_IDX_EFFECT_DONE = 8'h21;

	// Number of slots and slot field layout
	localparam int HWS_SLOTS = 8;
	localparam int HWS_DELAY_BIT = 7;
	localparam int HWS_FIELD_W = 7;
	localparam logic [6:0] HWS_FIELD_ZERO = 7'h00;
	localparam logic [7:0] HWS_SLOT_RESET = 8'h00;

	// Trigger bit within the trigger register
	localparam int HWS_TRIGGER_BIT = 0;

	// Delay timebase: 10 ms per unit at a 100 MHz clock
	localparam int HWS_CLK_HZ = 100_000_000;
	localparam int HWS_TICK_MS = 10;
	localparam int HWS_TICK_CYCLES = HWS_CLK_HZ / 1000 * HWS_TICK_MS;

	// Sequencer states
	typedef enum logic [2:0] {
		HWS_IDLE,
		HWS_FETCH,
		HWS_PLAY,
		HWS_WAIT,
		HWS_NEXT
	} hws_state_e;

endpackage : hws_pkg

/* File: design/hws_tick_if.sv */
// Interface carrying the delay timebase between sequencer and tick divider
`timescale 1ns/1ns
`default_nettype none
interface hws_tick_if;
	logic run;
	logic tick;
	modport source (input run, output tick);
	modport sink (output run, input tick);
endinterface : hws_tick_if
`default_nettype wire

/* File: design/hws_tick.sv */
// Divider that makes the fixed 10 ms delay tick from the device clock
`timescale 1ns/1ns
`default_nettype none
module hws_tick
	import hws_pkg::*;
#(
	parameter int TICK_CYCLES = HWS_TICK_CYCLES
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Tick carrier
	hws_tick_if.source tk
);

	logic [31:0] count; // Cycle counter inside one tick
	logic [31:0] next_count;
	logic next_tick;

	// Count while running; restart whenever stopped
	always_comb begin
		next_count = 32'h0000_0000;
		next_tick = 1'b0;
		if (tk.run) begin
			if (count == 32'(TICK_CYCLES - 1)) begin
				next_tick = 1'b1;
			end else begin
				next_count = count + 32'h0000_0001;
			end
		end
	end

	// Register counter and tick pulse
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			count <= 32'h0000_0000;
			tk.tick <= 1'b0;
		end else begin
			count <= next_count;
			tk.tick <= next_tick;
		end
	end

endmodule : hws_tick
`default_nettype wire

/* File: dv/hws_sequencer_properties.sv */
// Checker of the sequencer's port behaviour
`timescale 1ns/1ns
`default_nettype none
module hws_seq_chk (
	// Clock, reset and bus
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	// Playback side
	input wire logic EFFECT_START,
	input wire logic [6:0] EFFECT_INDEX,
	input wire logic EFFECT_DONE,
	input wire logic BUSY,
	input wire logic IDLING
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	chk_delay_quiet: assert property (IDLING |-> !EFFECT_START)
		else $error("start in delay");
	chk_delay_hold: assert property ($rose(IDLING) |-> IDLING[*8])
		else $error("delay short");
	chk_play_busy: assert property (EFFECT_START |-> BUSY)
		else $error("start idle");
	chk_index_nonzero: assert property (EFFECT_START |-> EFFECT_INDEX != 0)
		else $error("zero index");
	chk_trigger_starts: assert property (PSEL && PENABLE && PWRITE &&
		PADDR == 32'h30 && PWDATA[0] |=> BUSY) else $error("no start");
	chk_done_next: assert property (EFFECT_DONE && BUSY && !IDLING
		|-> ##[1:6] (EFFECT_START || IDLING || !BUSY)) else $error("stall");
	chk_start_pulse: assert property (EFFECT_START |=> !EFFECT_START)
		else $error("long start");
	chk_stop_quiet: assert property (!BUSY |-> !EFFECT_START && !IDLING)
		else $error("active when stopped");
endmodule : hws_seq_chk
bind hws_sequencer hws_seq_chk u_chk (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.EFFECT_START(EFFECT_START), .EFFECT_INDEX(EFFECT_INDEX),
	.EFFECT_DONE(EFFECT_DONE), .BUSY(BUSY), .IDLING(IDLING));
`default_nettype wire

/* File: dv/hws_sequencer_tb.sv */
// Self-checking bench of the slot sequencer
`timescale 1ns/1ns
`default_nettype none
module hws_sequencer_tb;
	logic clk, rstn, psel, pen, pwr, done, pready, err, start, busy, idling;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [6:0] index;
	int num_errors, checks_done, seed, r;
	int slot [8];
	// Device with a ten-cycle tick
	hws_sequencer #(.TICK_CYCLES(10)) u_dut (.CLK(clk), .RESETN(rstn),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(err),
		.EFFECT_START(start), .EFFECT_INDEX(index), .EFFECT_DONE(done),
		.BUSY(busy), .IDLING(idling));
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	task automatic hang;
		num_errors++;
		complete_run();
	endtask : hang
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer, answer taken at the ready edge
	task automatic apb(input logic w, input logic [31:0] a, d);
		int c;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (pready !== 1'b1 && c < 50);
		if (c >= 50) hang();
		rd = prdata;
		r = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	// Trigger, answer each effect and time each delay
	task automatic play;
		int f, k, c;
		apb(1'b1, 32'h30, 32'h1);
		for (k = 0; k < 8; k++) begin
			f = slot[k] & 127;
			if (f == 0) break;
			c = 0;
			do begin
				@(posedge clk);
				c++;
			end while (start !== 1'b1 && idling !== 1'b1 && c < 900);
			if (c >= 900) hang();
			if (slot[k] > 127) begin
				c = 1;
				while (idling === 1'b1 && c < 900) begin
					@(posedge clk);
					c++;
				end
				chk(c >= f * 10 && c <= f * 10 + 5, 1);
			end else begin
				chk(index, f);
				repeat ($random(seed) & 3) @(posedge clk);
				done <= 1'b1;
				@(posedge clk);
				done <= 1'b0;
			end
		end
		repeat (8) @(posedge clk);
		chk(busy, 0);
	endtask : play
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rstn, psel, pen, pwr, done, paddr, pwdata} = '0;
		seed = 32'h5A2A5A9B;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, 32'h48, 0);
		chk(rd, 0);
		apb(1'b0, 32'h4C, 0);
		chk(rd, 0);
		apb(1'b1, 32'h100, 32'hFF);
		chk(r, 1);
		$display("reset test done");
		for (int s = 0; s < 2; s++) begin
			for (int k = 0; k < 8; k++) begin
				r = $random(seed);
				slot[k] = r[7] ? 8'h81 + (r & 7) : (r & 127) | 1;
				if (k == 3) slot[k] = 8'h82;
				if (s == 1 && k == 4) slot[k] = 0;
				apb(1'b1, 32'h3C + 4 * k, slot[k]);
			end
			apb(1'b0, 32'h4C, 0);
			chk(rd, slot[4]);
			play();
			$display("sequence test %0d done", s);
		end
		complete_run();
	end
endmodule : hws_sequencer_tb
`default_nettype wire
